/* core/vec_pkg.sv */
package vec_pkg;
    localparam int NUM_SRC = 25;
    localparam int ADDR_W = 16;
    localparam int IDX_W = 5;
    // Larger part: two-word vectors, boot reset at word 0x1C00
    localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;
    localparam logic [ADDR_W-1:0] VEC_BASE = 16'h0002;
    localparam logic [ADDR_W-1:0] VEC_STEP_BIG = 16'h0002;
    localparam logic [ADDR_W-1:0] BOOT_ADDR_BIG = 16'h1C00;
    // Smaller part: one-word vectors, boot reset at 0xC00
    localparam logic [ADDR_W-1:0] VEC_STEP_SMALL = 16'h0001;
    localparam logic [ADDR_W-1:0] BOOT_ADDR_SMALL = 16'h0C00;
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic [IDX_W-1:0] IDX_EXT0 = 5'h00;
    localparam logic [IDX_W-1:0] IDX_TWI = 5'h17;
    localparam logic [IDX_W-1:0] IDX_SPM = 5'h18;
endpackage : vec_pkg

/* core/prio_pick.sv */
module prio_pick
    import vec_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input wire logic [N-1:0] req_i,
    output logic any_o,
    output logic [IDX_W-1:0] idx_o
);
    always_comb begin
        any_o = 1'b0;
        idx_o = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                any_o = 1'b1;
                idx_o = IDX_W'(i);
            end
        end
    end
endmodule : prio_pick

/* core/reset_irq_vector_placement.sv */
// How it works
// - After reset fetch starts at zero while the fuse is unprogrammed
// - Larger part: two-word vectors from 0x0002 onward
// - Timer, SPI, USART vectors continue from 0x0014
// - Last vectors ADC through store-program at 0x0032
// - Programmed fuse sends reset to boot address
// - Relocation adds boot start to every vector
// - Fuse and bit choose reset and vector base
// - Fuse one unprogrammed, zero programmed
// - Smaller part: boot 0xC00, vectors 0x01..0x19, relocated 0xC01..0xC19
module reset_irq_vector_placement
    import vec_pkg::*;
#(
    parameter bit LARGE_PART = 1'b1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic boot_reset_select_fuse_i,
    input wire logic vector_table_relocate_i,
    input wire logic [NUM_SRC-1:0] irq_req_i,
    input wire logic irq_ack_i,
    output logic fetch_valid_o,
    output logic [ADDR_W-1:0] fetch_addr_o,
    output logic irq_pending_o,
    output logic [IDX_W-1:0] irq_index_o,
    output logic [ADDR_W-1:0] irq_vector_o
);
    // Fuse captured after reset release, never in the reset branch
    logic fuse_q;
    logic fuse_cap_q;
    logic any;
    logic [IDX_W-1:0] idx;
    logic [ADDR_W-1:0] boot_addr;
    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] rst_addr_d;
    logic [ADDR_W-1:0] vec_d;

    assign boot_addr = LARGE_PART ? BOOT_ADDR_BIG : BOOT_ADDR_SMALL;
    assign step = LARGE_PART ? VEC_STEP_BIG : VEC_STEP_SMALL;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fuse_cap_q <= 1'b0;
            fuse_q <= 1'b1;
        end else if (!fuse_cap_q) begin
            fuse_cap_q <= 1'b1;
            fuse_q <= boot_reset_select_fuse_i;
        end
    end

    prio_pick #(.N(NUM_SRC)) u_pick (
        .req_i(irq_req_i),
        .any_o(any),
        .idx_o(idx)
    );

    always_comb begin
        // Fuse zero means programmed
        rst_addr_d = (boot_reset_select_fuse_i == FUSE_PROGRAMMED) ? boot_addr
                                                                   : RESET_ADDR;
        // Table base is one step past reset slot in either part
        vec_d = ADDR_W'(step + ADDR_W'(idx) * step);
        if (vector_table_relocate_i) begin
            vec_d = ADDR_W'(vec_d + boot_addr);
        end
    end

    // First fetch goes out in the first cycle after release
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fetch_valid_o <= 1'b0;
            fetch_addr_o <= RESET_ADDR;
        end else if (!fuse_cap_q) begin
            fetch_valid_o <= 1'b1;
            fetch_addr_o <= rst_addr_d;
        end else begin
            fetch_valid_o <= 1'b0;
        end
    end

    // Held until the core acknowledges; a newer lower request waits
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_pending_o <= 1'b0;
            irq_index_o <= '0;
            irq_vector_o <= '0;
        end else if (!irq_pending_o || irq_ack_i) begin
            irq_pending_o <= any && fuse_cap_q;
            irq_index_o <= idx;
            irq_vector_o <= vec_d;
        end
    end

    a_reset_target: assert property (@(posedge clk_i) disable iff (!nrst_i)
        fetch_valid_o |-> fetch_addr_o == ((fuse_q == FUSE_PROGRAMMED) ? boot_addr
                                                                     : RESET_ADDR))
        else $error("reset fetch address wrong");
    a_fetch_once: assert property (@(posedge clk_i) disable iff (!nrst_i)
        fetch_valid_o |=> !fetch_valid_o [*4])
        else $error("reset fetch repeated");
    a_vector_map: assert property (@(posedge clk_i) disable iff (!nrst_i)
        irq_pending_o && !$past(vector_table_relocate_i) && $rose(irq_pending_o) |->
        irq_vector_o == ADDR_W'(step + ADDR_W'(irq_index_o) * step))
        else $error("vector address wrong");
    a_vector_reloc: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(irq_pending_o) && $past(vector_table_relocate_i) |->
        irq_vector_o == ADDR_W'(boot_addr + step + ADDR_W'(irq_index_o) * step))
        else $error("relocated vector wrong");
    a_spm_last: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(irq_pending_o) && irq_index_o == IDX_SPM && !$past(vector_table_relocate_i)
        |-> irq_vector_o == (LARGE_PART ? 16'h0032 : 16'h0019))
        else $error("last vector wrong");
    a_lowest_wins: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(irq_pending_o) |-> $past(irq_req_i[0]) -> irq_index_o == IDX_EXT0)
        else $error("priority wrong");
    a_hold_pending: assert property (@(posedge clk_i) disable iff (!nrst_i)
        irq_pending_o && !irq_ack_i |=> irq_pending_o && $stable(irq_vector_o))
        else $error("pending vector dropped");
    a_small_boot: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !LARGE_PART && $rose(irq_pending_o) && $past(vector_table_relocate_i) &&
        irq_index_o == IDX_SPM |-> irq_vector_o == 16'h0C19)
        else $error("small boot vector wrong");
    a_fuse_sense: assert property (@(posedge clk_i) disable iff (!nrst_i)
        fetch_valid_o && fuse_q |-> fetch_addr_o == RESET_ADDR)
        else $error("unprogrammed fuse moved reset");
endmodule : reset_irq_vector_placement

/* dv/core_model.sv */
module core_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic pending_i,
    input wire logic [1:0] lat_i,
    output logic ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_q;
    // Core may sit on an offer, so the hold of the offer gets exercised
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_q <= 2'h0;
            ack_o <= 1'b0;
        end else begin
            wait_q <= (pending_i && !ack_o) ? wait_q + 2'h1 : 2'h0;
            ack_o <= pending_i && !ack_o && (wait_q >= lat_i);
        end
    end
endmodule : core_model

/* dv/testbench.sv */
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    import vec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, nrst_i = 1'b0, fuse = 1'b1, reloc = 1'b0, ack, fv, pend;
    logic [NUM_SRC-1:0] req = '0;
    logic [1:0] lat = 2'h0;
    logic [ADDR_W-1:0] fa, vec;
    logic [IDX_W-1:0] idx;
    int n_fail = 0, samples_checked = 0, cycles = 0;
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    reset_irq_vector_placement #(.LARGE_PART(1'b1)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .boot_reset_select_fuse_i(fuse), .vector_table_relocate_i(reloc), .irq_req_i(req),
        .irq_ack_i(ack), .fetch_valid_o(fv), .fetch_addr_o(fa), .irq_pending_o(pend),
        .irq_index_o(idx), .irq_vector_o(vec));
    core_model u_core (.clk_i(clk_i), .nrst_i(nrst_i), .pending_i(pend), .lat_i(lat),
        .ack_o(ack));
    task do_reset(input logic f);
        nrst_i <= 1'b0;
        fuse <= f;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i); #1;
        `CHK(fv, 1'b1)
        `CHK(fa, f ? RESET_ADDR : BOOT_ADDR_BIG)
        @(posedge clk_i); #1;
        `CHK(fv, 1'b0)
    endtask : do_reset
    task offer(input logic [NUM_SRC-1:0] r, input logic rl, input logic [IDX_W-1:0] ei,
        input logic [1:0] l);
        logic [ADDR_W-1:0] ev;
        int k;
        ev = 16'h0002 * (ei + 1) + (rl ? BOOT_ADDR_BIG : 16'h0000);
        @(posedge clk_i);
        req <= r;
        reloc <= rl;
        lat <= l;
        k = 0;
        do begin @(posedge clk_i); #1; k++; end while (pend !== 1'b1 && k < 20);
        `CHK(idx, ei)
        `CHK(vec, ev)
        @(posedge clk_i); #1;
        req <= '0;
        k = 0;
        while (ack !== 1'b1 && k < 20) begin @(posedge clk_i); #1; k++; end
        // Offer must stand even though requests dropped
        `CHK(vec, ev)
        @(posedge clk_i); #1;
    endtask : offer
    task report_and_stop;
        $display("checks=%0d errors=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    initial begin
        do_reset(1'b1);
        for (int rl = 0; rl < 2; rl++) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                offer(NUM_SRC'(1) << i, rl[0], IDX_W'(i), 2'(i));
            end
        end
        offer('1, 1'b0, 5'h00, 2'h3);
        offer(25'h1800000, 1'b1, 5'h17, 2'h1);
        do_reset(1'b0);
        offer(25'h1000000, 1'b1, 5'h18, 2'h0);
        report_and_stop();
    end
endmodule : testbench
